// ===== src/term_port_pkg.sv
package term_port_pkg;
  localparam logic [7:0] PTR_MODE = 8'h00;
  localparam logic [7:0] PTR_STATUS = 8'h01;
  localparam logic [7:0] PTR_DISPLAY = 8'h02;
  localparam logic [7:0] PTR_KEYBOARD = 8'h03;
  localparam logic [7:0] PTR_LINE_END = 8'h04;
  localparam logic [7:0] PTR_ERASE_BACK = 8'h05;
  localparam logic [7:0] PTR_LINE_DELETE = 8'h06;
  localparam logic [7:0] PTR_VECTOR = 8'h07;
  localparam logic [7:0] PTR_WINDOW = 8'h1d;
  localparam logic [7:0] PTR_IRQ_CTRL = 8'h1e;
  localparam int BIT_DISPLAY_BUSY = 0;
  localparam int BIT_KEY_READY = 1;
  localparam int BIT_DISPLAY_EN = 0;
  localparam int BIT_KEYBOARD_EN = 1;
  localparam int BIT_BLOCK = 2;
  localparam int BIT_PARAMS = 3;
  localparam int BIT_XFER_EN = 3;
  localparam logic [2:0] CMD_CLEAR_IP_IUS = 3'b001;
  localparam logic [2:0] CMD_SET_IE = 3'b110;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int BLOCK_MAX = 64;
  localparam int CURSOR_CODES = 8;
  localparam logic [5:0] WIN_CURSOR_BASE = 6'h20;
  localparam logic [3:0] SETUP_CYCLES = 4'h8;
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_WDATA = 8'h04;
  localparam logic [7:0] WB_RDATA = 8'h08;
  localparam logic [7:0] WB_STATE = 8'h0c;
endpackage : term_port_pkg

// ===== src/term_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface term_port_if;
  logic sel_n;
  logic wr_n;
  logic rd_n;
  logic ad_sel;
  logic [7:0] host_d;
  logic [7:0] dev_d;
  logic dev_d_oe;
  logic irq_n;
  logic iack_n;
  modport dev(input sel_n, wr_n, rd_n, ad_sel, host_d, iack_n, output dev_d, dev_d_oe, irq_n);
  modport host(output sel_n, wr_n, rd_n, ad_sel, host_d, iack_n, input dev_d, dev_d_oe, irq_n);
endinterface : term_port_if
`default_nettype wire

// ===== src/sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  input wire logic clk_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta;
  always_ff @(posedge clk_in) begin
    meta <= d_in;
    q_out <= meta;
  end
endmodule : sync2
`default_nettype wire

// ===== src/term_port_dev.sv
`timescale 1ns/100ps
`default_nettype none
module term_port_dev
  import term_port_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  term_port_if.dev BUS,
  input wire logic [7:0] KEY_DATA_IN,
  input wire logic KEY_STROBE_IN,
  output logic [7:0] DISP_DATA_OUT,
  output logic DISP_STROBE_OUT,
  output logic [7:0] MODE_OUT,
  output logic [7:0] LINE_END_OUT,
  output logic [7:0] ERASE_BACK_OUT,
  output logic [7:0] LINE_DELETE_OUT
);
  import term_port_pkg::*;
  logic sel_s, wr_s, rd_s, ack_s, ad_s;
  logic [7:0] hd_s;
  logic wr_d, rd_d, ack_d;
  logic [7:0] ptr;
  logic [5:0] win_ptr;
  logic [7:0] mem [0:127];
  logic [7:0] vector, display_data, keyboard_data;
  logic busy, ready, busy_d, ready_d;
  logic ie, irq_in_service_latch, ip, xfer_en;
  logic [3:0] setup_cnt;
  logic [6:0] blk_left;
  logic [5:0] blk_rd;
  logic blk_active;
  logic kstb_s, kstb_d;
  logic [7:0] kd_s1, kd_s2;
  logic [7:0] rd_val;
  logic wr_pulse, rd_end, ack_pulse, key_ev;

  sync2 u_sel (.clk_in(CLK_SYS_IN), .d_in(~BUS.sel_n), .q_out(sel_s));
  sync2 u_wr (.clk_in(CLK_SYS_IN), .d_in(~BUS.wr_n), .q_out(wr_s));
  sync2 u_rd (.clk_in(CLK_SYS_IN), .d_in(~BUS.rd_n), .q_out(rd_s));
  sync2 u_ack (.clk_in(CLK_SYS_IN), .d_in(~BUS.iack_n), .q_out(ack_s));
  sync2 u_ad (.clk_in(CLK_SYS_IN), .d_in(BUS.ad_sel), .q_out(ad_s));
  sync2 u_ks (.clk_in(CLK_SYS_IN), .d_in(~KEY_STROBE_IN), .q_out(kstb_s));
  genvar g;
  for (g = 0; g < 8; g++) begin : g_hd
    sync2 u_hd (.clk_in(CLK_SYS_IN), .d_in(BUS.host_d[g]), .q_out(hd_s[g]));
  end

  // Key data is steady while the strobe is low, so a plain two-stage copy is safe
  always_ff @(posedge CLK_SYS_IN) begin
    kd_s1 <= KEY_DATA_IN;
    kd_s2 <= kd_s1;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      wr_d <= 1'b0;
      rd_d <= 1'b0;
      ack_d <= 1'b0;
      kstb_d <= 1'b0;
      busy_d <= 1'b0;
      ready_d <= 1'b0;
    end else begin
      wr_d <= wr_s & sel_s;
      rd_d <= rd_s & sel_s;
      ack_d <= ack_s;
      kstb_d <= kstb_s;
      busy_d <= busy;
      ready_d <= ready;
    end
  end
  assign wr_pulse = wr_s & sel_s & ~wr_d & xfer_en;
  assign rd_end = ~(rd_s & sel_s) & rd_d & xfer_en;
  assign ack_pulse = ack_s & ~ack_d;
  assign key_ev = kstb_s & ~kstb_d;

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      setup_cnt <= 4'h0;
      xfer_en <= 1'b0;
    end else if (setup_cnt != SETUP_CYCLES) begin
      setup_cnt <= setup_cnt + 4'h1;
    end else begin
      xfer_en <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ptr <= RESET_BYTE;
    end else if (wr_pulse && !ad_s) begin
      ptr <= hd_s;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      MODE_OUT <= RESET_BYTE;
      vector <= RESET_BYTE;
      LINE_END_OUT <= RESET_BYTE;
      ERASE_BACK_OUT <= RESET_BYTE;
      LINE_DELETE_OUT <= RESET_BYTE;
    end else if (wr_pulse && ad_s) begin
      unique case (ptr)
        PTR_MODE: MODE_OUT <= hd_s;
        PTR_VECTOR: vector <= hd_s;
        PTR_LINE_END: LINE_END_OUT <= hd_s;
        PTR_ERASE_BACK: ERASE_BACK_OUT <= hd_s;
        PTR_LINE_DELETE: LINE_DELETE_OUT <= hd_s;
        default: ;
      endcase
    end
  end

  // Parameter codes land at the cursor base; block data at zero
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      win_ptr <= 6'h00;
    end else if (wr_pulse && ad_s && ptr == PTR_MODE && hd_s[BIT_PARAMS]) begin
      win_ptr <= WIN_CURSOR_BASE;
    end else if (wr_pulse && ad_s && ptr == PTR_DISPLAY) begin
      win_ptr <= 6'h00;
    end else if (ptr == PTR_WINDOW && ad_s && (wr_pulse || rd_end)) begin
      win_ptr <= win_ptr + 6'h01;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_pulse && ad_s && ptr == PTR_WINDOW) begin
      mem[{1'b0, win_ptr}] <= hd_s;
    end else if (key_ev && MODE_OUT[BIT_KEYBOARD_EN] && MODE_OUT[BIT_BLOCK]) begin
      mem[{1'b1, blk_rd}] <= kd_s2;
    end
  end

  // Display side: host sets busy with a status write, device clears it
  // A char written while the display is off is kept and leaves once it is on
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      busy <= 1'b0;
      display_data <= RESET_BYTE;
      DISP_DATA_OUT <= RESET_BYTE;
      DISP_STROBE_OUT <= 1'b0;
      blk_left <= 7'h00;
      blk_active <= 1'b0;
    end else begin
      DISP_STROBE_OUT <= 1'b0;
      if (wr_pulse && ad_s && ptr == PTR_DISPLAY && !busy) begin
        display_data <= hd_s;
      end
      if (wr_pulse && ad_s && ptr == PTR_STATUS && hd_s[BIT_DISPLAY_BUSY]) begin
        busy <= 1'b1;
      end else if (busy && !blk_active && MODE_OUT[BIT_DISPLAY_EN]) begin
        if (MODE_OUT[BIT_BLOCK]) begin
          if (display_data[5:0] == 6'h00) begin
            busy <= 1'b0;
          end else begin
            blk_left <= {1'b0, display_data[5:0]};
            blk_active <= 1'b1;
          end
        end else begin
          DISP_DATA_OUT <= display_data;
          DISP_STROBE_OUT <= 1'b1;
          busy <= 1'b0;
        end
      end else if (blk_active) begin
        DISP_DATA_OUT <= mem[{1'b0, display_data[5:0] - blk_left[5:0]}];
        DISP_STROBE_OUT <= 1'b1;
        blk_left <= blk_left - 7'h01;
        if (blk_left == 7'h01) begin
          blk_active <= 1'b0;
          busy <= 1'b0;
        end
      end
    end
  end

  // Keyboard: device sets ready, host clears it; set wins
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ready <= 1'b0;
      keyboard_data <= RESET_BYTE;
      blk_rd <= 6'h00;
    end else begin
      if (wr_pulse && ad_s && ptr == PTR_STATUS && !hd_s[BIT_KEY_READY]) begin
        ready <= 1'b0;
        blk_rd <= 6'h00;
      end
      if (key_ev && MODE_OUT[BIT_KEYBOARD_EN]) begin
        if (MODE_OUT[BIT_BLOCK]) begin
          if (blk_rd != 6'h3f) begin
            blk_rd <= blk_rd + 6'h01;
          end
          keyboard_data <= {2'b00, blk_rd + 6'h01};
        end else begin
          keyboard_data <= kd_s2;
        end
        ready <= 1'b1;
      end
    end
  end

  // Pending on ready rise or busy fall while enabled; 001 and 110 commands
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ie <= 1'b0;
      ip <= 1'b0;
      irq_in_service_latch <= 1'b0;
    end else begin
      if (wr_pulse && ad_s && ptr == PTR_IRQ_CTRL) begin
        if (hd_s[7:5] == CMD_CLEAR_IP_IUS) begin
          ip <= 1'b0;
          irq_in_service_latch <= 1'b0;
        end else if (hd_s[7:5] == CMD_SET_IE) begin
          ie <= 1'b1;
        end
      end
      if (ack_pulse && ip) begin
        irq_in_service_latch <= 1'b1;
      end
      if (ie && ((ready && !ready_d) || (!busy && busy_d))) begin
        ip <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_val = RESET_BYTE;
    unique case (ptr)
      PTR_MODE: rd_val = MODE_OUT;
      PTR_STATUS: rd_val = {6'h00, ready, busy};
      PTR_DISPLAY: rd_val = display_data;
      PTR_KEYBOARD: rd_val = keyboard_data;
      PTR_LINE_END: rd_val = LINE_END_OUT;
      PTR_ERASE_BACK: rd_val = ERASE_BACK_OUT;
      PTR_LINE_DELETE: rd_val = LINE_DELETE_OUT;
      PTR_VECTOR: rd_val = vector;
      PTR_WINDOW: rd_val = mem[{MODE_OUT[BIT_BLOCK] && MODE_OUT[BIT_KEYBOARD_EN], win_ptr}];
      PTR_IRQ_CTRL: rd_val = {ie, irq_in_service_latch, ip, 1'b0, xfer_en, 3'h0};
      default: rd_val = RESET_BYTE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      BUS.dev_d <= RESET_BYTE;
      BUS.dev_d_oe <= 1'b0;
      BUS.irq_n <= 1'b1;
    end else begin
      BUS.irq_n <= ~(ip && !irq_in_service_latch);
      if (ack_s && ip) begin
        BUS.dev_d <= vector;
        BUS.dev_d_oe <= 1'b1;
      end else if (rd_s && sel_s && ad_s) begin
        BUS.dev_d <= rd_val;
        BUS.dev_d_oe <= 1'b1;
      end else begin
        BUS.dev_d_oe <= 1'b0;
      end
    end
  end
endmodule : term_port_dev
`default_nettype wire

// ===== src/term_port_host.sv
`timescale 1ns/100ps
`default_nettype none
// Wishbone slave; CMD write starts one bus access on the port
module term_port_host
  import term_port_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  term_port_if.host BUS,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT
);
  import term_port_pkg::*;
  typedef enum logic [1:0] {IDLE = 2'b00, SETUP = 2'b01, STROBE = 2'b11, HOLD = 2'b10} hstate_t;
  hstate_t state;
  logic [7:0] wdata, rdata;
  logic [3:0] cmd;
  logic [3:0] cnt;
  logic [7:0] dd_s1, dd_s2;
  logic oe_s1, oe_s2;
  logic irq_s1, irq_s2;
  logic req;

  // Read data is held by the device for the whole strobe
  always_ff @(posedge CLK_SYS_IN) begin
    dd_s1 <= BUS.dev_d;
    dd_s2 <= dd_s1;
    oe_s1 <= BUS.dev_d_oe;
    oe_s2 <= oe_s1;
    irq_s1 <= ~BUS.irq_n;
    irq_s2 <= irq_s1;
  end

  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
      wdata <= RESET_BYTE;
      cmd <= 4'h0;
    end else begin
      WB_ACK_OUT <= req;
      if (req && WB_WE_IN && WB_ADR_IN == WB_WDATA && WB_SEL_IN[0]) begin
        wdata <= WB_DAT_IN[7:0];
      end
      if (req && WB_WE_IN && WB_ADR_IN == WB_CMD && WB_SEL_IN[0] && state == IDLE) begin
        cmd <= WB_DAT_IN[3:0];
      end else if (state == HOLD) begin
        cmd <= 4'h0;
      end
      if (req && !WB_WE_IN) begin
        unique case (WB_ADR_IN)
          WB_RDATA: WB_DAT_OUT <= {24'h0, rdata};
          WB_STATE: WB_DAT_OUT <= {29'h0, irq_s2, state != IDLE || cmd[0], oe_s2};
          WB_WDATA: WB_DAT_OUT <= {24'h0, wdata};
          default: WB_DAT_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end

  // cmd: bit0 go, bit1 read, bit2 ad level (0 pointer, 1 data), bit3 acknowledge cycle
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state <= IDLE;
      cnt <= 4'h0;
      rdata <= RESET_BYTE;
      BUS.sel_n <= 1'b1;
      BUS.wr_n <= 1'b1;
      BUS.rd_n <= 1'b1;
      BUS.ad_sel <= 1'b0;
      BUS.host_d <= RESET_BYTE;
      BUS.iack_n <= 1'b1;
    end else begin
      unique case (state)
        IDLE: if (cmd[0]) begin
          BUS.ad_sel <= cmd[2];
          BUS.host_d <= wdata;
          cnt <= 4'h0;
          state <= SETUP;
        end
        SETUP: begin
          BUS.sel_n <= cmd[3];
          BUS.iack_n <= ~cmd[3];
          BUS.wr_n <= cmd[1] | cmd[3];
          BUS.rd_n <= ~cmd[1] | cmd[3];
          state <= STROBE;
        end
        STROBE: begin
          cnt <= cnt + 4'h1;
          if (cnt == SETUP_CYCLES) begin
            rdata <= dd_s2;
            BUS.sel_n <= 1'b1;
            BUS.iack_n <= 1'b1;
            BUS.wr_n <= 1'b1;
            BUS.rd_n <= 1'b1;
            cnt <= 4'h0;
            state <= HOLD;
          end
        end
        HOLD: begin
          cnt <= cnt + 4'h1;
          if (cnt == SETUP_CYCLES) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule : term_port_host
`default_nettype wire

// ===== tb/term_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
module term_port_sva
  import term_port_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic ad_sel,
  input wire logic [7:0] host_d,
  input wire logic [7:0] dev_d,
  input wire logic dev_d_oe,
  input wire logic irq_n,
  input wire logic iack_n
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic wr_q;
  logic ie_set;
  logic [7:0] ptr;
  logic [7:0] mode;
  logic [7:0] vec;
  // Seen at strobe start; the device syncs first, so its copy lands later
  wire wr_go = wr_q && !wr_n && !sel_n;
  wire dat_wr = wr_go && ad_sel;
  always_ff @(posedge CLK_SYS_IN) begin
    wr_q <= SYS_RST_IN || wr_n;
  end
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) ptr <= PTR_MODE;
    else if (wr_go && !ad_sel) ptr <= host_d;
  end
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      mode <= RESET_BYTE;
      vec <= RESET_BYTE;
    end else begin
      if (dat_wr && ptr == PTR_MODE) mode <= host_d;
      if (dat_wr && ptr == PTR_VECTOR) vec <= host_d;
    end
  end
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) ie_set <= 1'b0;
    else if (dat_wr && ptr == PTR_IRQ_CTRL && host_d[7:5] == CMD_SET_IE) ie_set <= 1'b1;
  end
  sequence s_rd(logic [7:0] p);
    !sel_n && !rd_n && ad_sel && dev_d_oe && ptr == p;
  endsequence
  sequence s_idle;
    (rd_n && iack_n) [*6];
  endsequence
  sequence s_clr;
    dat_wr && ptr == PTR_IRQ_CTRL && host_d[7:5] == CMD_CLEAR_IP_IUS;
  endsequence
  a_vector_store: assert property (s_rd(PTR_VECTOR) |-> dev_d == vec)
    else $error("vector readback wrong");
  a_ack_vector: assert property (!iack_n && rd_n && dev_d_oe |-> dev_d == vec)
    else $error("ack vector wrong");
  a_mode_store: assert property (s_rd(PTR_MODE) |-> dev_d == mode)
    else $error("mode readback wrong");
  a_ctrl_flags: assert property (s_rd(PTR_IRQ_CTRL) |-> dev_d[7] == ie_set && dev_d[BIT_XFER_EN])
    else $error("control flags wrong");
  a_irq_no_enable: assert property (!ie_set |-> irq_n)
    else $error("irq without enable");
  a_irq_clear: assert property (s_clr |-> ##[1:8] irq_n)
    else $error("irq not cleared");
  a_read_drive: assert property ($fell(rd_n) && !sel_n && ad_sel |=> ##[0:5] dev_d_oe)
    else $error("read not driven");
  a_oe_release: assert property (s_idle |-> !dev_d_oe)
    else $error("bus held after read");
endmodule : term_port_sva
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import term_port_pkg::*;
  typedef struct {logic [7:0] p; logic [7:0] d;} row_t;
  logic clk;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] key_data;
  logic key_strobe_n;
  logic [7:0] disp_data;
  logic disp_strobe;
  logic [7:0] mode;
  logic [7:0] line_end;
  logic [7:0] erase_back;
  logic [7:0] line_delete;
  logic [7:0] v;
  logic [7:0] cnt0;
  logic [7:0] disp_last;
  int error_cnt = 0;
  int checks_done = 0;
  int disp_cnt = 0;
  row_t rows[5];
  term_port_if bus();
  term_port_dev term_port_dev_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .BUS(bus), .KEY_DATA_IN(key_data),
    .KEY_STROBE_IN(key_strobe_n), .DISP_DATA_OUT(disp_data), .DISP_STROBE_OUT(disp_strobe), .MODE_OUT(mode),
    .LINE_END_OUT(line_end), .ERASE_BACK_OUT(erase_back), .LINE_DELETE_OUT(line_delete));
  term_port_host term_port_host_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .BUS(bus), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack));
  term_port_sva term_port_sva_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .sel_n(bus.sel_n), .wr_n(bus.wr_n),
    .rd_n(bus.rd_n), .ad_sel(bus.ad_sel), .host_d(bus.host_d), .dev_d(bus.dev_d), .dev_d_oe(bus.dev_d_oe),
    .irq_n(bus.irq_n), .iack_n(bus.iack_n));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Ack and read data are taken at the rising edge that shows ack; one idle edge follows
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      tally_and_finish();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Command byte: bit0 go, bit1 read, bit2 data phase, bit3 acknowledge cycle
  task automatic cmd_run(input logic [7:0] c, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] s;
    int n;
    n = 0;
    wb(1'b1, WB_WDATA, d, s);
    wb(1'b1, WB_CMD, c, s);
    do begin
      wb(1'b0, WB_STATE, 8'h00, s);
      n++;
    end while (s[1] !== 1'b0 && n < 30);
    if (n >= 30) begin
      error_cnt++;
      tally_and_finish();
    end
    wb(1'b0, WB_RDATA, 8'h00, q);
  endtask : cmd_run
  task automatic port(input logic ad, input logic r, input logic [7:0] d, output logic [7:0] q);
    cmd_run({5'h00, ad, r, 1'b1}, d, q);
  endtask : port
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] s;
    port(1'b0, 1'b0, p, s);
    port(1'b1, 1'b0, d, s);
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic [7:0] s;
    port(1'b0, 1'b0, p, s);
    port(1'b1, 1'b1, 8'h00, q);
  endtask : rd
  task automatic irq_is(input logic e);
    @(negedge clk);
    check("irq_n", {7'h00, bus.irq_n}, {7'h00, e});
    @(posedge clk);
  endtask : irq_is
  task automatic irq_ack;
    wr(PTR_IRQ_CTRL, 8'h20);
    irq_is(1'b1);
    wr(PTR_IRQ_CTRL, 8'hc0);
  endtask : irq_ack
  task automatic key(input logic [7:0] d);
    key_data <= d;
    key_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    key_strobe_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : key
  always @(posedge clk) begin
    if (disp_strobe === 1'b1) begin
      disp_cnt++;
      disp_last = disp_data;
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rows = '{'{PTR_MODE, 8'h03}, '{PTR_LINE_END, 8'h0d}, '{PTR_ERASE_BACK, 8'h08},
      '{PTR_LINE_DELETE, 8'h18}, '{PTR_VECTOR, 8'h5a}};
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    key_data = 8'h00;
    key_strobe_n = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    rd(PTR_IRQ_CTRL, v);
    check("ctrl", v, 8'h08);
    irq_is(1'b1);
    wb(1'b0, 8'h10, 8'h00, v);
    check("unmapped", v, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].p, rows[i].d);
      rd(rows[i].p, v);
      check("readback", v, rows[i].d);
    end
    check("mode", mode, 8'h03);
    check("line end", line_end, 8'h0d);
    check("erase back", erase_back, 8'h08);
    check("line delete", line_delete, 8'h18);
    wr(PTR_IRQ_CTRL, 8'hc0);
    rd(PTR_IRQ_CTRL, v);
    check("ctrl ie", v, 8'h88);
    rd(PTR_STATUS, v);
    check("busy idle", v & 8'h01, 8'h00);
    cnt0 = 8'(disp_cnt);
    wr(PTR_DISPLAY, 8'h41);
    wr(PTR_STATUS, 8'h01);
    rd(PTR_STATUS, v);
    check("busy", v & 8'h03, 8'h00);
    check("disp cnt", 8'(disp_cnt), cnt0 + 8'h01);
    check("disp char", disp_last, 8'h41);
    irq_is(1'b0);
    irq_ack();
    // Display off: busy must stay up and nothing leaves until it is back on
    wr(PTR_MODE, 8'h02);
    cnt0 = 8'(disp_cnt);
    wr(PTR_DISPLAY, 8'h42);
    wr(PTR_STATUS, 8'h01);
    rd(PTR_STATUS, v);
    check("busy held", v & 8'h01, 8'h01);
    check("disp held", 8'(disp_cnt), cnt0);
    wr(PTR_MODE, 8'h03);
    rd(PTR_STATUS, v);
    check("late char", disp_last, 8'h42);
    irq_ack();
    key(8'h37);
    rd(PTR_STATUS, v);
    check("ready", v & 8'h02, 8'h02);
    irq_is(1'b0);
    cmd_run(8'h09, 8'h00, v);
    check("ack vector", v, 8'h5a);
    rd(PTR_IRQ_CTRL, v);
    check("ctrl ius", v, 8'he8);
    rd(PTR_KEYBOARD, v);
    check("key", v, 8'h37);
    wr(PTR_STATUS, 8'h00);
    rd(PTR_STATUS, v);
    check("ready clr", v & 8'h02, 8'h00);
    irq_ack();
    rd(PTR_IRQ_CTRL, v);
    check("ctrl clr", v, 8'h88);
    wr(PTR_MODE, 8'h01);
    key(8'h38);
    rd(PTR_STATUS, v);
    check("kbd off", v & 8'h02, 8'h00);
    wr(PTR_MODE, 8'h0b);
    port(1'b0, 1'b0, PTR_WINDOW, v);
    for (int i = 0; i < CURSOR_CODES; i++) port(1'b1, 1'b0, 8'h60 + 8'(i), v);
    wr(PTR_MODE, 8'h0b);
    port(1'b0, 1'b0, PTR_WINDOW, v);
    for (int i = 0; i < CURSOR_CODES; i++) begin
      port(1'b1, 1'b1, 8'h00, v);
      check("cursor", v, 8'h60 + 8'(i));
    end
    wr(PTR_MODE, 8'h07);
    cnt0 = 8'(disp_cnt);
    wr(PTR_DISPLAY, 8'h03);
    port(1'b0, 1'b0, PTR_WINDOW, v);
    for (int i = 0; i < 3; i++) port(1'b1, 1'b0, 8'h70 + 8'(i), v);
    wr(PTR_STATUS, 8'h01);
    rd(PTR_STATUS, v);
    check("blk busy", v & 8'h01, 8'h00);
    check("blk cnt", 8'(disp_cnt), cnt0 + 8'h03);
    check("blk last", disp_last, 8'h72);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    rd(PTR_IRQ_CTRL, v);
    check("ctrl rst", v, 8'h08);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
